// *** btre_pkg.sv ***
/*
 * btre_pkg: shared constants of the block transfer raster engine.
 * Assumes: included by name only, nothing imported anywhere.
 */
package btre_pkg;
   // register word indices; byte address is four times the index
   localparam logic [5:0] IDX_PITCH = 6'h00;
   localparam logic [5:0] IDX_CTRL = 6'h04;
   localparam logic [5:0] IDX_SRC = 6'h05;
   localparam logic [5:0] IDX_DST = 6'h06;
   localparam logic [5:0] IDX_CMD = 6'h07;
   localparam logic [5:0] IDX_FG = 6'h08;
   localparam logic [5:0] IDX_BG = 6'h09;
   localparam logic [5:0] IDX_PAT = 6'h20;   // 32 pattern words follow
   localparam int PAT_WORDS = 32;             // 8x8 pixels at 16 bpp
   // control register fields
   localparam int CTL_ROP_LSB = 0;
   localparam int CTL_INC_Y = 8;
   localparam int CTL_INC_X = 9;
   localparam int CTL_SRC_FIXED = 10;
   localparam int CTL_SRC_MONO = 11;
   localparam int CTL_PAT_MONO = 12;
   localparam int CTL_BG_TRANSP = 13;
   localparam int CTL_TYPE_LSB = 14;
   localparam int CTL_SEED_LSB = 16;
   localparam int CTL_BUSY = 20;
   localparam int CTL_BPP16 = 24;
   localparam logic [31:0] CTL_WMASK = 32'h0107_FFFF;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   // transfer types
   localparam logic [1:0] XFER_SCREEN = 2'h0;
   localparam logic [1:0] XFER_HOST = 2'h1;
   // bit and byte walking
   localparam logic [2:0] MONO_TOP = 3'h7;
   localparam logic [1:0] BYTE_LAST = 2'h3;
   localparam logic [7:0] ALL_SET = 8'hFF;
   // engine sequence
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SRC = 3'b001,
      ST_HWAIT = 3'b010,
      ST_SRD = 3'b011,
      ST_DST = 3'b100,
      ST_CALC = 3'b101,
      ST_WR = 3'b110,
      ST_NEXT = 3'b111
   } btre_state_t;
endpackage : btre_pkg

// *** btre_rop_if.sv ***
/*
 * btre_rop_if: operands and result of the three-operand logic unit.
 * Assumes: engine and logic unit share one scope, purely combinational.
 */
`timescale 1ns/1ps
interface btre_rop_if;
   logic [7:0] rop;   // operation code
   logic [7:0] s;     // source byte
   logic [7:0] d;     // destination byte
   logic [7:0] p;     // pattern byte
   logic [7:0] res;   // combined byte
   modport eng (output rop, output s, output d, output p, input res);
   modport alu (input rop, input s, input d, input p, output res);
endinterface : btre_rop_if

// *** btre_rop.sv ***
/*
 * btre_rop: bitwise three-operand raster operation.
 * Assumes: operands stable in the cycle the engine samples res.
 */
`timescale 1ns/1ps
module btre_rop (
   // operands and result
   btre_rop_if.alu op
);
   // each result bit indexes the code by its pattern, source, dest bits
   for (genvar i = 0; i < 8; i++) begin : g_bit
      assign op.res[i] = op.rop[{op.p[i], op.s[i], op.d[i]}];
   end
endmodule : btre_rop

// *** btre_expand.sv ***
/*
 * btre_expand: picks one monochrome bit and turns it into a colour byte.
 * Assumes: caller chooses the byte half for 16 bpp colours.
 */
`timescale 1ns/1ps
module btre_expand (
   // monochrome input
   input wire logic [7:0] mono_byte,
   input wire logic [2:0] bit_pos,
   // colours
   input wire logic [15:0] fg,
   input wire logic [15:0] bg,
   input wire logic hi_sel,
   // result
   output logic bit_out,
   output logic [7:0] byte_out
);
   logic [15:0] colour;   // chosen pixel colour

   assign bit_out = mono_byte[bit_pos];
   assign colour = bit_out ? fg : bg;
   assign byte_out = hi_sel ? colour[15:8] : colour[7:0];
endmodule : btre_expand

// *** btre_engine.sv ***
/*
 * btre_engine: block transfer raster engine with APB registers.
 * Assumes: byte-wide frame buffer port with an ack on the same clock,
 * host source words arriving on a valid/ready port on the same clock.
 */
// How it works
// - host and screen sources, mono expansion, 8/16bpp
// - any of 256 codes combines S, D, P
// - own 8x8 pattern, mono or colour
// - source copy code passes source unchanged
// - separate source and destination pitches
// - rows of bytes apart by pitch, counts bytes
// - direction bits choose row and byte stepping
// - control holds type, depths, background, seed
// - address registers hold the starting corner byte
// - command write starts the transfer
// - control bit 20 shows engine busy
// - engine handles byte alignment itself
// - pattern read only when code uses it
// - colours used only for expansion or fills
// - host writes become source data
// - host start byte, drop leftovers, offset stepping
// - mono bits 7..0, bytes 0..3, left to right
`timescale 1ns/1ps
module btre_engine #(
   parameter int AW = 21   // frame buffer byte address width
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // frame buffer byte port
   output logic mem_req,
   output logic mem_we,
   output logic [AW-1:0] mem_addr,
   output logic [7:0] mem_wdata,
   input wire logic [7:0] mem_rdata,
   input wire logic mem_ack,
   // host source words
   input wire logic host_valid,
   input wire logic [31:0] host_data,
   output logic host_ready
);
   btre_pkg::btre_state_t state_q, state_d;   // engine sequence

   // programmed registers
   logic [31:0] pitch_q;
   logic [31:0] ctl_q;
   logic [AW-1:0] src_q;
   logic [AW-1:0] dst_q;
   logic [31:0] cmd_q;
   logic [15:0] fg_q;
   logic [15:0] bg_q;
   logic [31:0] pat_q [btre_pkg::PAT_WORDS];
   logic [31:0] prdata_q;

   // walking state
   logic [AW-1:0] src_ptr_q, src_line_q, dst_ptr_q, dst_line_q, maddr_q;
   logic [15:0] bcnt_q, lcnt_q;   // bytes left in line, lines left
   logic [2:0] line_idx_q;        // line number for pattern rows
   logic [7:0] sb_q, db_q, wb_q;  // source, dest and result bytes
   logic sb_valid_q;
   logic [2:0] mbit_q;            // next mono bit
   logic half_q;                  // second byte of a 16 bpp pixel
   logic [31:0] hw_q;             // held host word
   logic hw_valid_q;
   logic [1:0] hidx_q, hidx_line_q;

   // bus decode
   logic acc, wr, rd_setup, idle, mapped, start;
   logic [5:0] idx;
   assign idx = paddr[7:2];
   assign acc = psel & penable;
   assign wr = acc & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign idle = (state_q == btre_pkg::ST_IDLE);
   assign mapped = (idx <= btre_pkg::IDX_BG && (idx == btre_pkg::IDX_PITCH ||
                   idx >= btre_pkg::IDX_CTRL)) || idx >= btre_pkg::IDX_PAT;
   // empty blocks never leave idle
   assign start = wr & idle & (idx == btre_pkg::IDX_CMD) &
                  (|pwdata[15:0]) & (|pwdata[31:16]);
   assign pready = 1'b1;   // every access completes without wait
   assign pslverr = acc & ~mapped;
   assign prdata = prdata_q;

   // control fields
   logic [7:0] rop;
   logic inc_x, inc_y, src_fixed, mono, pat_mono, transp, bpp16, host_src;
   logic [2:0] seed;
   logic [15:0] sp, dp;
   assign rop = ctl_q[btre_pkg::CTL_ROP_LSB +: 8];
   assign inc_y = ctl_q[btre_pkg::CTL_INC_Y];
   assign inc_x = ctl_q[btre_pkg::CTL_INC_X];
   assign src_fixed = ctl_q[btre_pkg::CTL_SRC_FIXED];
   assign mono = ctl_q[btre_pkg::CTL_SRC_MONO];
   assign pat_mono = ctl_q[btre_pkg::CTL_PAT_MONO];
   assign transp = ctl_q[btre_pkg::CTL_BG_TRANSP];
   assign seed = ctl_q[btre_pkg::CTL_SEED_LSB +: 3];
   assign bpp16 = ctl_q[btre_pkg::CTL_BPP16];
   // other type codes fall back to screen source
   assign host_src = (ctl_q[btre_pkg::CTL_TYPE_LSB +: 2] == btre_pkg::XFER_HOST);
   assign sp = pitch_q[15:0];
   assign dp = pitch_q[31:16];

   // which operands the code really depends on
   logic s_used, d_used, p_used;
   assign s_used = (rop[1:0] != rop[3:2]) | (rop[5:4] != rop[7:6]);
   assign d_used = (rop[0] != rop[1]) | (rop[2] != rop[3]) |
                   (rop[4] != rop[5]) | (rop[6] != rop[7]);
   assign p_used = (rop[3:0] != rop[7:4]);

   // stepping; mono source only walks left to right
   logic fwd_x;
   logic [AW-1:0] xstep;
   assign fwd_x = mono | inc_x;
   assign xstep = fwd_x ? AW'(1) : {AW{1'b1}};

   logic line_end, last_line, need_src, skip;
   assign line_end = (bcnt_q == 16'h0001);
   assign last_line = (lcnt_q == 16'h0001);
   // colour source needs a byte per output byte, mono a byte per 8 bits
   assign need_src = s_used & ~src_fixed & (~mono | ~sb_valid_q);

   // monochrome source and fixed colour expansion
   logic s_bit;
   logic [7:0] s_exp;
   btre_expand u_src_exp (
      .mono_byte(src_fixed ? btre_pkg::ALL_SET : sb_q),
      .bit_pos(mbit_q),
      .fg(fg_q),
      .bg(bg_q),
      .hi_sel(bpp16 & (src_fixed ? dst_ptr_q[0] : half_q)),
      .bit_out(s_bit),
      .byte_out(s_exp)
   );

   // pattern lookup: row from seed and line, column from dest address
   logic [2:0] prow, ppix;
   logic [6:0] pidx;
   logic [7:0] pat_byte, p_exp;
   assign prow = seed + line_idx_q;
   assign ppix = bpp16 ? dst_ptr_q[3:1] : dst_ptr_q[2:0];
   assign pidx = pat_mono ? {4'h0, prow} :
                 bpp16 ? {prow, dst_ptr_q[3:0]} : {1'b0, prow, dst_ptr_q[2:0]};
   assign pat_byte = pat_q[pidx[6:2]][8*pidx[1:0] +: 8];
   btre_expand u_pat_exp (
      .mono_byte(pat_byte),
      .bit_pos(~ppix),
      .fg(fg_q),
      .bg(bg_q),
      .hi_sel(bpp16 & dst_ptr_q[0]),
      .bit_out(),
      .byte_out(p_exp)
   );

   // three-operand logic unit
   btre_rop_if rif ();
   assign rif.rop = rop;
   assign rif.s = (src_fixed | mono) ? s_exp : sb_q;
   assign rif.d = d_used ? db_q : btre_pkg::ALL_SET;
   assign rif.p = ~p_used ? btre_pkg::ALL_SET : pat_mono ? p_exp : pat_byte;
   btre_rop u_rop (
      .op(rif.alu)
   );

   // transparent background leaves clear mono bits unwritten
   assign skip = mono & transp & s_used & ~s_bit;

   // frame buffer and host handshakes
   assign mem_req = (state_q == btre_pkg::ST_SRD) | (state_q == btre_pkg::ST_WR) |
                    ((state_q == btre_pkg::ST_DST) & d_used);
   assign mem_we = (state_q == btre_pkg::ST_WR);
   assign mem_addr = maddr_q;
   assign mem_wdata = wb_q;
   assign host_ready = (state_q == btre_pkg::ST_HWAIT);

   // register writes; ignored while a transfer runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pitch_q <= btre_pkg::RST_WORD;
         ctl_q <= btre_pkg::RST_WORD;
         src_q <= '0;
         dst_q <= '0;
         cmd_q <= btre_pkg::RST_WORD;
         fg_q <= '0;
         bg_q <= '0;
      end else if (wr & idle) begin
         unique case (idx)
            btre_pkg::IDX_PITCH: pitch_q <= pwdata;
            btre_pkg::IDX_CTRL: ctl_q <= pwdata & btre_pkg::CTL_WMASK;
            btre_pkg::IDX_SRC: src_q <= pwdata[AW-1:0];
            btre_pkg::IDX_DST: dst_q <= pwdata[AW-1:0];
            btre_pkg::IDX_CMD: cmd_q <= pwdata;
            btre_pkg::IDX_FG: fg_q <= pwdata[15:0];
            btre_pkg::IDX_BG: bg_q <= pwdata[15:0];
            default: ;   // pattern words and holes
         endcase
      end
   end

   // pattern words; not cleared by reset, software loads them if used
   always_ff @(posedge pclk) begin
      if (wr & idle & (idx >= btre_pkg::IDX_PAT)) begin
         pat_q[idx[4:0]] <= pwdata;
      end
   end

   // read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= btre_pkg::RST_WORD;
      end else if (rd_setup) begin
         prdata_q <= btre_pkg::RST_WORD;   // holes read as zero
         if (idx >= btre_pkg::IDX_PAT) begin
            prdata_q <= pat_q[idx[4:0]];
         end else begin
            unique case (idx)
               btre_pkg::IDX_PITCH: prdata_q <= pitch_q;
               btre_pkg::IDX_CTRL: begin
                  prdata_q <= ctl_q;
                  prdata_q[btre_pkg::CTL_BUSY] <= ~idle;
               end
               btre_pkg::IDX_SRC: prdata_q <= 32'(src_q);
               btre_pkg::IDX_DST: prdata_q <= 32'(dst_q);
               btre_pkg::IDX_CMD: prdata_q <= cmd_q;
               btre_pkg::IDX_FG: prdata_q <= {16'h0000, fg_q};
               btre_pkg::IDX_BG: prdata_q <= {16'h0000, bg_q};
               default: ;
            endcase
         end
      end
   end

   // sequence: fetch source, fetch dest, combine, write, advance
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         btre_pkg::ST_IDLE: if (start) state_d = btre_pkg::ST_SRC;
         btre_pkg::ST_SRC: begin
            if (!need_src) state_d = btre_pkg::ST_DST;
            else if (!host_src) state_d = btre_pkg::ST_SRD;
            else if (hw_valid_q) state_d = btre_pkg::ST_DST;
            else state_d = btre_pkg::ST_HWAIT;
         end
         btre_pkg::ST_HWAIT: if (host_valid) state_d = btre_pkg::ST_SRC;
         btre_pkg::ST_SRD: if (mem_ack) state_d = btre_pkg::ST_DST;
         btre_pkg::ST_DST: if (!d_used || mem_ack) state_d = btre_pkg::ST_CALC;
         btre_pkg::ST_CALC: state_d = skip ? btre_pkg::ST_NEXT : btre_pkg::ST_WR;
         btre_pkg::ST_WR: if (mem_ack) state_d = btre_pkg::ST_NEXT;
         btre_pkg::ST_NEXT: begin
            state_d = (line_end & last_line) ? btre_pkg::ST_IDLE : btre_pkg::ST_SRC;
         end
      endcase
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) state_q <= btre_pkg::ST_IDLE;
      else state_q <= state_d;
   end

   // address held stable for each memory access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) maddr_q <= '0;
      else maddr_q <= (state_d == btre_pkg::ST_SRD) ? src_ptr_q : dst_ptr_q;
   end

   // pointers and counters: rows of bytes a pitch apart
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_ptr_q <= '0;
         src_line_q <= '0;
         dst_ptr_q <= '0;
         dst_line_q <= '0;
         bcnt_q <= '0;
         lcnt_q <= '0;
         line_idx_q <= '0;
      end else if (start) begin
         src_ptr_q <= src_q;
         src_line_q <= src_q;
         dst_ptr_q <= dst_q;
         dst_line_q <= dst_q;
         bcnt_q <= pwdata[15:0];
         lcnt_q <= pwdata[31:16];
         line_idx_q <= '0;
      end else if (state_q == btre_pkg::ST_SRD && mem_ack) begin
         src_ptr_q <= src_ptr_q + xstep;   // any byte alignment
      end else if (state_q == btre_pkg::ST_NEXT) begin
         if (line_end) begin
            // clear inc_y walks bottom to top
            src_line_q <= inc_y ? src_line_q + AW'(sp) : src_line_q - AW'(sp);
            src_ptr_q <= inc_y ? src_line_q + AW'(sp) : src_line_q - AW'(sp);
            dst_line_q <= inc_y ? dst_line_q + AW'(dp) : dst_line_q - AW'(dp);
            dst_ptr_q <= inc_y ? dst_line_q + AW'(dp) : dst_line_q - AW'(dp);
            bcnt_q <= cmd_q[15:0];
            lcnt_q <= lcnt_q - 16'h0001;
            line_idx_q <= line_idx_q + 3'h1;
         end else begin
            dst_ptr_q <= dst_ptr_q + xstep;
            bcnt_q <= bcnt_q - 16'h0001;
         end
      end
   end

   // source byte supply from memory or host words
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sb_q <= '0;
         sb_valid_q <= 1'b0;
         mbit_q <= btre_pkg::MONO_TOP;
         half_q <= 1'b0;
         hw_q <= btre_pkg::RST_WORD;
         hw_valid_q <= 1'b0;
         hidx_q <= '0;
         hidx_line_q <= '0;
      end else if (start) begin
         sb_valid_q <= 1'b0;
         mbit_q <= btre_pkg::MONO_TOP;
         half_q <= 1'b0;
         hw_valid_q <= 1'b0;
         hidx_q <= src_q[1:0];   // first byte in host word
         hidx_line_q <= src_q[1:0];
      end else begin
         unique case (state_q)
            btre_pkg::ST_HWAIT: begin
               if (host_valid) begin
                  hw_q <= host_data;
                  hw_valid_q <= 1'b1;
               end
            end
            btre_pkg::ST_SRC: begin
               if (need_src && host_src && hw_valid_q) begin
                  sb_q <= hw_q[8*hidx_q +: 8];   // bytes 0 to 3
                  sb_valid_q <= 1'b1;
                  hidx_q <= hidx_q + 2'h1;
                  if (hidx_q == btre_pkg::BYTE_LAST) hw_valid_q <= 1'b0;
               end
            end
            btre_pkg::ST_SRD: begin
               if (mem_ack) begin
                  sb_q <= mem_rdata;
                  sb_valid_q <= 1'b1;
               end
            end
            btre_pkg::ST_NEXT: begin
               if (line_end) begin
                  // leftover host bytes dropped at line end
                  sb_valid_q <= 1'b0;
                  mbit_q <= btre_pkg::MONO_TOP;
                  half_q <= 1'b0;
                  hw_valid_q <= 1'b0;
                  hidx_line_q <= hidx_line_q + sp[1:0];
                  hidx_q <= hidx_line_q + sp[1:0];
               end else if (mono) begin
                  // counts expanded bytes, two per bit at 16 bpp
                  if (!bpp16 || half_q) begin
                     half_q <= 1'b0;
                     mbit_q <= mbit_q - 3'h1;
                     if (mbit_q == 3'h0) sb_valid_q <= 1'b0;
                  end else begin
                     half_q <= 1'b1;
                  end
               end else begin
                  sb_valid_q <= 1'b0;
               end
            end
            default: ;
         endcase
      end
   end

   // destination byte and combined result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         db_q <= '0;
         wb_q <= '0;
      end else begin
         if (state_q == btre_pkg::ST_DST && d_used && mem_ack) db_q <= mem_rdata;
         if (state_q == btre_pkg::ST_CALC) wb_q <= rif.res;
      end
   end
endmodule : btre_engine

// *** btre_engine_monitor.sv ***
/*
 * btre_engine_monitor: port-level assertions for the raster engine.
 * Assumes: bound to btre_engine, one pclk domain, async low reset.
 */
`timescale 1ns/1ps
module btre_engine_monitor #(
   parameter int AW = 21   // frame buffer byte address width
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // frame buffer and host ports
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [AW-1:0] mem_addr,
   input wire logic mem_ack,
   input wire logic host_ready
);
   logic unm;   // word index outside the register map
   // pattern words fill the top half; 25 holes remain in the bottom half
   assign unm = !(paddr[7:2] == btre_pkg::IDX_PITCH || paddr[7:2] >= btre_pkg::IDX_PAT
      || (paddr[7:2] >= btre_pkg::IDX_CTRL && paddr[7:2] <= btre_pkg::IDX_BG));
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_high_a: assert property (pready)
      else $error("pready low");
   unmapped_err_a: assert property (psel && penable && unm |-> pslverr)
      else $error("unmapped access without error");
   mapped_ok_a: assert property (psel && penable && !unm |-> !pslverr)
      else $error("mapped access flagged");
   err_phase_a: assert property (pslverr |-> psel && penable)
      else $error("error outside access phase");
   unmapped_zero_a: assert property (psel && penable && !pwrite && unm |-> prdata == 0)
      else $error("unmapped read not zero");
   req_hold_a: assert property (mem_req && !mem_ack |=>
      mem_req && $stable(mem_addr) && $stable(mem_we))
      else $error("memory request dropped or moved");
   we_in_req_a: assert property (mem_we |-> mem_req)
      else $error("write strobe without request");
   host_quiet_a: assert property (host_ready |-> !mem_req)
      else $error("memory access while waiting for host");
   reset_quiet_a: assert property ($rose(presetn) |-> !mem_req && !host_ready && prdata == 0)
      else $error("activity right after reset");
endmodule : btre_engine_monitor
bind btre_engine btre_engine_monitor #(.AW(AW)) u_mon (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
   .mem_addr(mem_addr), .mem_ack(mem_ack), .host_ready(host_ready));

// *** btre_mem_model.sv ***
/*
 * btre_mem_model: byte-wide frame buffer behind the engine.
 * Assumes: one request pending at a time, held until the ack pulse.
 */
`timescale 1ns/1ps
module btre_mem_model #(
   parameter int AW = 12   // byte address width
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // engine side
   input wire logic mem_req,
   input wire logic mem_we,
   input wire logic [AW-1:0] mem_addr,
   input wire logic [7:0] mem_wdata,
   output logic [7:0] mem_rdata,
   output logic mem_ack,
   // extra wait cycles per access, set by the bench
   input wire logic [1:0] lat
);
   logic [7:0] mem [0:(1<<AW)-1];   // storage, preloaded by the bench
   logic [1:0] wait_q;   // cycles already waited on this request
   // one access per request; read data garbled outside the ack cycle
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mem_ack <= 1'b0;
         wait_q <= 2'h0;
         mem_rdata <= 8'h00;
      end else begin
         mem_ack <= 1'b0;
         if (mem_ack) begin
            mem_rdata <= ~mem_rdata;   // stale byte must never look valid
         end else if (mem_req && wait_q >= lat) begin
            mem_ack <= 1'b1;
            wait_q <= 2'h0;
            if (mem_we) begin
               mem[mem_addr] <= mem_wdata;
            end else begin
               mem_rdata <= mem[mem_addr];
            end
         end else if (mem_req) begin
            wait_q <= wait_q + 2'h1;   // slow answer
         end
      end
   end
endmodule : btre_mem_model

// *** tb.sv ***
/*
 * tb: self-checking bench for the raster engine over apb.
 * Assumes: memory model answers every request, host words fed on demand.
 */
`timescale 1ns/1ps
module tb;
   localparam int AW = 12;   // small frame buffer keeps the run short
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, host_data = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, mem_req, mem_we, mem_ack, host_ready, er, host_valid = 1'b0;
   logic [AW-1:0] mem_addr;
   logic [7:0] mem_wdata, mem_rdata;
   logic [1:0] lat = 2'h0;   // memory wait cycles
   logic [7:0] ref_q [0:(1<<AW)-1];   // expected frame buffer
   logic [31:0] w [3];   // host words
   logic [7:0] ops [8] = '{8'hCC, 8'h00, 8'hFF, 8'h66, 8'hF0, 8'h5A, 8'h88, 8'h3C};
   int bad_count = 0, check_count = 0, cyc = 0;
   int sp, dp, sa, da, ln, nb, k, x, st;
   always #20 pclk = ~pclk;
   // hang guard
   always @(posedge pclk) begin
      cyc++;
      if (cyc > 40000) begin
         bad_count++;
         give_verdict();
      end
   end
   btre_engine #(.AW(AW)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
      .host_valid(host_valid), .host_data(host_data), .host_ready(host_ready));
   btre_mem_model #(.AW(AW)) fb (.pclk(pclk), .presetn(presetn), .mem_req(mem_req),
      .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
      .mem_ack(mem_ack), .lat(lat));
   task automatic give_verdict;
      if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : give_verdict
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // expected raster op: each result bit indexed by pattern, source, dest
   function automatic logic [7:0] rop_f(input logic [7:0] op, s, d, p);
      logic [7:0] r;
      for (int i = 0; i < 8; i++) r[i] = op[{p[i], s[i], d[i]}];
      return r;
   endfunction : rop_f
   function automatic logic [7:0] ba(input logic [5:0] i);
      return {i, 2'b00};
   endfunction : ba
   // one apb transfer; request held until pready seen high
   task automatic apb(input logic wn, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wn;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // program, start, then poll the busy bit
   task automatic blit(input logic [31:0] ctl, s, d, pit, cmd);
      logic busy0;
      apb(1'b1, ba(btre_pkg::IDX_PITCH), pit);
      apb(1'b1, ba(btre_pkg::IDX_CTRL), ctl);
      apb(1'b1, ba(btre_pkg::IDX_SRC), s);
      apb(1'b1, ba(btre_pkg::IDX_DST), d);
      apb(1'b1, ba(btre_pkg::IDX_CMD), cmd);
      apb(1'b0, ba(btre_pkg::IDX_CTRL), 32'h0000_0000);
      busy0 = rd[20];
      while (rd[20] === 1'b1) apb(1'b0, ba(btre_pkg::IDX_CTRL), 32'h0000_0000);
      chk("busy at start", 32'(cmd[31:16] != 0 && cmd[15:0] != 0), 32'(busy0));
      chk("ctrl after run", ctl & btre_pkg::CTL_WMASK, rd);
      for (int a = 0; a < (1 << AW); a++)
         chk("frame byte", 32'(ref_q[a]), 32'(fb.mem[a]));
   endtask : blit
   initial begin
      void'($urandom(32'h26d9_666b));
      for (int a = 0; a < (1 << AW); a++) begin
         ref_q[a] = 8'($urandom);
         fb.mem[a] = ref_q[a];
      end
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ba(btre_pkg::IDX_CTRL), 32'h0000_0000);
      chk("ctrl reset", 32'h0000_0000, rd);
      apb(1'b0, 8'h40, 32'h0000_0000);
      chk("unmapped err", 32'h0000_0001, 32'(er));
      chk("unmapped data", 32'h0000_0000, rd);
      sp = $urandom;
      apb(1'b1, ba(btre_pkg::IDX_PITCH), sp);
      apb(1'b0, ba(btre_pkg::IDX_PITCH), 32'h0000_0000);
      chk("pitch", sp, rd);
      for (int i = 0; i < btre_pkg::PAT_WORDS; i++)
         apb(1'b1, ba(btre_pkg::IDX_PAT + 6'(i)), 32'hA5A5_A5A5);
      // high byte must stay unused at 8 bpp
      apb(1'b1, ba(btre_pkg::IDX_FG), 32'h0000_963C);
      ops[7] = 8'($urandom);
      // every direction pair, several codes, unaligned corners, one fill, last one empty
      for (int i = 0; i < 8; i++) begin
         sp = 32 + $urandom % 32;
         dp = 32 + $urandom % 32;
         sa = 'h400 + $urandom % 256;
         da = 'hA00 + $urandom % 256;
         ln = (i == 7) ? 0 : 1 + $urandom % 4;
         nb = 1 + $urandom % 8;
         lat <= 2'($urandom);
         for (int r = 0; r < ln; r++) for (int b = 0; b < nb; b++) begin
            k = sa + (i[0] ? r * sp : -r * sp) + (i[1] ? b : -b);
            x = da + (i[0] ? r * dp : -r * dp) + (i[1] ? b : -b);
            ref_q[AW'(x)] = rop_f(ops[i], (i == 6) ? 8'h3C : ref_q[AW'(k)],
               ref_q[AW'(x)], 8'hA5);
         end
         blit(32'(ops[i]) | (32'(i[1:0]) << 8) | (32'(i == 6) << 10),
            sa, da, {16'(dp), 16'(sp)},
            {16'(ln), 16'(nb)});
      end
      // host source: start byte 1, offset 2 wraps the next line into a new word
      k = 0;
      x = 1;
      st = 1;
      for (int j = 0; j < 3; j++) w[j] = $urandom;
      for (int r = 0; r < 2; r++) begin
         for (int b = 0; b < 3; b++) begin
            ref_q[AW'('h600 + r * 40 + b)] = w[k][8 * x +: 8];
            x = (x + 1) % 4;
            if (x == 0) k++;
         end
         if (x != 0) k++;
         st = (st + 2) % 4;
         x = st;
      end
      fork
         blit(32'h0000_43CC, 32'h0000_0001, 32'h0000_0600, 32'h0028_0002,
            32'h0002_0003);
         begin
            @(posedge pclk);
            for (int j = 0; j < 3; j++) begin
               host_valid <= 1'b1;
               host_data <= w[j];
               do @(posedge pclk); while (host_ready !== 1'b1);
            end
            host_valid <= 1'b0;
            host_data <= ~w[2];
         end
      join
      give_verdict();
   end
endmodule : tb
